// ===== src/cfgd_map.svh
// Purpose: Offsets, field positions, reset values and counts of the configuration word decoder
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one aligned word per register
// Notes: Definitions only
`ifndef CFGD_MAP_SVH
`define CFGD_MAP_SVH
// Register byte offsets
`define CFGD_OFS_WORD 4'h0
`define CFGD_OFS_CTRL 4'h4
`define CFGD_OFS_STAT 4'h8
// Configuration word field positions
`define CFGD_BOR_HI 9
`define CFGD_BOR_LO 8
`define CFGD_DPROT_BIT 7
`define CFGD_PPROT_BIT 6
`define CFGD_MASTER_CLEAR_RESET_BIT 5
`define CFGD_POWER_UP_DELAY_TIMER_BIT 4
`define CFGD_WDT_BIT 3
`define CFGD_OSC_HI 2
`define CFGD_OSC_LO 0
// Erased word: every fuse reads one
`define CFGD_WORD_RESET 14'h3fff
// Edges after reset release until the synchroniser shows the real word
`define CFGD_SYNC_SETTLE 2'h2
// Control register fields and reset value
`define CFGD_CTRL_SBOR 0
`define CFGD_CTRL_SWDT 1
`define CFGD_CTRL_RESET 2'h0
// Status register field positions
`define CFGD_ST_BOR 0
`define CFGD_ST_WDT 1
`define CFGD_ST_DPROT 2
`define CFGD_ST_PPROT 3
`define CFGD_ST_POWER_UP_DELAY_TIMER 4
`define CFGD_ST_MASTER_CLEAR_RESET 5
`define CFGD_ST_LOADED 6
`define CFGD_ST_OSC_LO 8
// Clock output runs at one quarter of the system clock
`define CFGD_CLKOUT_DIV 4
`define CFGD_CLKOUT_HALF 2'h1
`endif

// ===== src/cfgd_pkg.sv
// Purpose: Types shared by the configuration word decoder
// Assumes: Nothing is imported; users write cfgd_pkg::name
// Notes: Codes match the fuse encodings
package cfgd_pkg;
  // Brown-out mode select encodings
  typedef enum logic [1:0] {
    cfgd_bor_off = 2'b00,
    cfgd_bor_soft = 2'b01,
    cfgd_bor_run_a = 2'b10,
    cfgd_bor_run_b = 2'b11
  } cfgd_bor_t;
  // Oscillator mode select encodings
  typedef enum logic [2:0] {
    cfgd_osc_low_power_crystal = 3'b000,
    cfgd_osc_mid_crystal = 3'b001,
    cfgd_osc_high_crystal = 3'b010,
    cfgd_osc_external_clock = 3'b011,
    cfgd_osc_internal_pins_free = 3'b100,
    cfgd_osc_internal_clock_out = 3'b101,
    cfgd_osc_res_cap_pin_free = 3'b110,
    cfgd_osc_res_cap_clock_out = 3'b111
  } cfgd_osc_t;
endpackage

// ===== src/cfgd_osc_if.sv
// Purpose: Carries oscillator mode and pin roles between decoder modules
// Assumes: One clock domain
// Notes: dec reads the mode and drives the pin roles and clock; use_side drives the mode and reads the rest
`timescale 1ns/10ps
interface cfgd_osc_if;
  cfgd_pkg::cfgd_osc_t mode; // Latched oscillator mode
  logic osc1_gpio; // First oscillator pin free for digital use
  logic osc2_gpio; // Second oscillator pin free for digital use
  logic clkout_en; // Second pin drives the clock output
  logic clkout; // Quarter-rate clock output level
  modport dec (input mode, output osc1_gpio, output osc2_gpio, output clkout_en, output clkout);
  modport use_side (output mode, input osc1_gpio, input osc2_gpio, input clkout_en, input clkout);
endinterface

// ===== src/cfgd_sync.sv
// Purpose: Two-flop synchroniser for pin-level inputs
// Assumes: Inputs are static or slow levels
// Notes: First stage feeds only the second
`timescale 1ns/10ps
module cfgd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  input wire logic [WIDTH-1:0] i_reset_val,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg; // First stage, may be metastable

  // Both stages reset to the idle level of the line
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= i_reset_val;
      o_sync <= i_reset_val;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

// ===== src/cfgd_osc_decode.sv
// Purpose: Oscillator mode to pin roles and quarter-rate clock output
// Assumes: Mode is constant after load
// Notes: Outputs are flops
`timescale 1ns/10ps
`include "cfgd_map.svh"
module cfgd_osc_decode (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  cfgd_osc_if.dec osc
);
  logic [1:0] div_reg; // Quarter-rate phase counter
  logic osc1_free; // Decoded first pin role
  logic osc2_free; // Decoded second pin role
  logic clk_drive; // Decoded clock-out role

  // Pin roles per mode; crystal and external-clock codes hold both pins
  assign osc1_free = (osc.mode == cfgd_pkg::cfgd_osc_internal_pins_free)
    || (osc.mode == cfgd_pkg::cfgd_osc_internal_clock_out);
  assign osc2_free = (osc.mode == cfgd_pkg::cfgd_osc_internal_pins_free)
    || (osc.mode == cfgd_pkg::cfgd_osc_res_cap_pin_free);
  assign clk_drive = (osc.mode == cfgd_pkg::cfgd_osc_res_cap_clock_out)
    || (osc.mode == cfgd_pkg::cfgd_osc_internal_clock_out);

  // Register pin roles; the clock toggles every half period of the divider
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      div_reg <= 2'h0;
      osc.clkout <= 1'b0;
      osc.osc1_gpio <= 1'b0;
      osc.osc2_gpio <= 1'b0;
      osc.clkout_en <= 1'b0;
    end
    else
    begin
      div_reg <= (div_reg == `CFGD_CLKOUT_HALF) ? 2'h0 : div_reg + 2'h1;
      if (div_reg == `CFGD_CLKOUT_HALF)
      begin
        osc.clkout <= ~osc.clkout;
      end
      osc.osc1_gpio <= osc1_free;
      osc.osc2_gpio <= osc2_free;
      osc.clkout_en <= clk_drive;
    end
  end

  // Clock output toggles every two cycles while driven
  clk_half_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (div_reg == `CFGD_CLKOUT_HALF) |=> (osc.clkout != $past(osc.clkout)))
    else $error("clock output missed its toggle");
endmodule

// ===== src/cfgd_config_word_decode.sv
// Purpose: Latch the configuration word at reset release and drive static chip controls
// Assumes: Word and pin inputs come from outside the clock domain; sleep is local logic
// Notes: Avalon-MM slave answers every access one cycle after it is raised
`timescale 1ns/10ps
`include "cfgd_map.svh"
module cfgd_config_word_decode #(
  parameter int WORD_W = 14
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Configuration word from the non-volatile array
  input wire logic [WORD_W-1:0] i_config_word,
  // Shared master clear pin level
  input wire logic i_master_clear_pin,
  // Core is in sleep
  input wire logic i_sleep,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Decoded controls
  output logic o_brownout_reset_enable,
  output logic o_data_memory_protect,
  output logic o_program_memory_protect,
  output logic o_master_clear_reset,
  output logic o_master_clear_pin_digital,
  output logic o_power_up_delay_timer_enable,
  output logic o_watchdog_timer_enable,
  output logic [2:0] o_oscillator_mode_select,
  output logic o_osc1_gpio,
  output logic o_osc2_gpio,
  // Second oscillator pin as clock output
  output logic o_clock_output,
  output logic o_clock_output_oe
);
  cfgd_osc_if osc (); // Oscillator mode and pin roles

  logic [WORD_W-1:0] word_sync; // Word after two flops
  logic master_clear_reset_pin_sync; // Pin level after two flops
  logic [WORD_W-1:0] word_reg; // Latched configuration word
  logic loaded_reg; // Word captured since reset
  logic [1:0] settle_reg; // Edges since release, stops at the settle count
  logic settle_done; // Synchroniser now shows the pin-side word
  logic [1:0] ctrl_reg; // Soft enables
  logic [1:0] ctrl_next; // Soft enables after a write
  logic ack_reg; // Access answered this cycle
  logic [31:0] rdata_next; // Read mux
  logic [31:0] status_word; // Live decoded state
  logic req; // Any access raised
  logic hit_word; // Address decodes
  logic hit_ctrl;
  logic hit_stat;
  logic wr_ctrl; // Control write takes effect
  cfgd_pkg::cfgd_bor_t bor_mode; // Brown-out field
  logic bor_next; // Decoded brown-out enable
  logic wdt_next; // Decoded watchdog enable
  logic master_clear_reset_next; // Decoded reset request

  // Word and pin leave their own timing through two flops each
  cfgd_sync #(
    .WIDTH(WORD_W)
  ) u_word_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_config_word),
    .i_reset_val(WORD_W'(`CFGD_WORD_RESET)),
    .o_sync(word_sync)
  );

  // Pin idles high, so reset state means no reset request
  cfgd_sync #(
    .WIDTH(1)
  ) u_master_clear_reset_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_master_clear_pin),
    .i_reset_val(1'b1),
    .o_sync(master_clear_reset_pin_sync)
  );

  // Oscillator pin roles and clock output divider
  cfgd_osc_decode u_osc (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .osc(osc.dec)
  );

  // Every code lands on an enum member: 000/001/010 crystal, 011 external clock
  assign osc.mode = cfgd_pkg::cfgd_osc_t'(word_reg[`CFGD_OSC_HI:`CFGD_OSC_LO]);

  // Load timing after reset release:
  //   edge 1  first synchroniser stage takes the pin-side word
  //   edge 2  second stage shows it; the counter reaches its end
  //   edge 3  the word is captured and loaded_reg rises
  //   edge 4  decoded controls and oscillator pin roles follow
  // Capturing on edge 1 would only latch the synchroniser's own reset value,
  // so a burnt word would never reach the decode.
  // The counter stops once loaded, so it costs no switching in normal running.
  assign settle_done = (settle_reg == `CFGD_SYNC_SETTLE);

  // One capture once settled; later word changes are ignored until reset
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      word_reg <= WORD_W'(`CFGD_WORD_RESET);
      loaded_reg <= 1'b0;
      settle_reg <= 2'h0;
    end
    else if (!loaded_reg)
    begin
      // Count the synchroniser stages, then take the word
      settle_reg <= settle_done ? settle_reg : settle_reg + 2'h1;
      if (settle_done)
      begin
        word_reg <= word_sync;
        loaded_reg <= 1'b1;
      end
    end
  end

  // Field decoding
  assign bor_mode = cfgd_pkg::cfgd_bor_t'(word_reg[`CFGD_BOR_HI:`CFGD_BOR_LO]);
  always_comb
  begin
    unique case (bor_mode)
      cfgd_pkg::cfgd_bor_run_a,
      cfgd_pkg::cfgd_bor_run_b: bor_next = !i_sleep;
      cfgd_pkg::cfgd_bor_soft: bor_next = ctrl_reg[`CFGD_CTRL_SBOR];
      cfgd_pkg::cfgd_bor_off: bor_next = 1'b0;
    endcase
  end
  // Fuse forces the watchdog; otherwise software decides
  assign wdt_next = word_reg[`CFGD_WDT_BIT] | ctrl_reg[`CFGD_CTRL_SWDT];
  // Pin as digital input keeps the internal reset line inactive
  assign master_clear_reset_next = word_reg[`CFGD_MASTER_CLEAR_RESET_BIT] & !master_clear_reset_pin_sync;

  // Controls are flops so downstream units never see decode glitches
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_brownout_reset_enable <= 1'b0;
      o_data_memory_protect <= 1'b0;
      o_program_memory_protect <= 1'b0;
      o_master_clear_reset <= 1'b0;
      o_master_clear_pin_digital <= 1'b0;
      o_power_up_delay_timer_enable <= 1'b0;
      o_watchdog_timer_enable <= 1'b0;
      o_oscillator_mode_select <= 3'h0;
    end
    else
    begin
      o_brownout_reset_enable <= bor_next;
      o_data_memory_protect <= !word_reg[`CFGD_DPROT_BIT];
      o_program_memory_protect <= !word_reg[`CFGD_PPROT_BIT];
      o_master_clear_reset <= master_clear_reset_next;
      o_master_clear_pin_digital <= !word_reg[`CFGD_MASTER_CLEAR_RESET_BIT];
      o_power_up_delay_timer_enable <= !word_reg[`CFGD_POWER_UP_DELAY_TIMER_BIT];
      o_watchdog_timer_enable <= wdt_next;
      o_oscillator_mode_select <= osc.mode;
    end
  end

  // Pin roles come straight from the oscillator flops
  assign o_osc1_gpio = osc.osc1_gpio;
  assign o_osc2_gpio = osc.osc2_gpio;
  assign o_clock_output = osc.clkout;
  assign o_clock_output_oe = osc.clkout_en;

  // Bus decode; misaligned or unmapped addresses hit nothing
  assign req = i_avs_read | i_avs_write;
  assign hit_word = (i_avs_address == `CFGD_OFS_WORD);
  assign hit_ctrl = (i_avs_address == `CFGD_OFS_CTRL);
  assign hit_stat = (i_avs_address == `CFGD_OFS_STAT);
  // Write lands on the edge where waitrequest is low; only lane 0 holds bits
  assign wr_ctrl = i_avs_write & ack_reg & hit_ctrl & i_avs_byteenable[0];
  assign ctrl_next = wr_ctrl ? i_avs_writedata[1:0] : ctrl_reg;
  // Holding waitrequest for one cycle gives the read mux a flop stage
  assign o_avs_waitrequest = req & !ack_reg;

  // Status reflects the outputs actually driven
  assign status_word = {21'h0, o_oscillator_mode_select, 1'b0, loaded_reg,
    o_master_clear_pin_digital, o_power_up_delay_timer_enable,
    o_program_memory_protect, o_data_memory_protect,
    o_watchdog_timer_enable, o_brownout_reset_enable};
  assign rdata_next = hit_word ? {{(32 - WORD_W){1'b0}}, word_reg} :
    hit_ctrl ? {30'h0, ctrl_reg} :
    hit_stat ? status_word : 32'h0;

  // Answer bookkeeping and soft enables
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      ack_reg <= 1'b0;
      ctrl_reg <= `CFGD_CTRL_RESET;
      o_avs_readdata <= 32'h0;
    end
    else
    begin
      ack_reg <= req & !ack_reg;
      ctrl_reg <= ctrl_next;
      if (i_avs_read & !ack_reg)
      begin
        o_avs_readdata <= rdata_next;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  // Steps of a bus access
  sequence acc_wait_s;
    req && o_avs_waitrequest;
  endsequence
  sequence acc_done_s;
    !o_avs_waitrequest;
  endsequence

  bor_run_a: assert property (
    (loaded_reg && bor_mode[1] && !i_sleep) |=> o_brownout_reset_enable)
    else $error("brown-out off while running");
  bor_sleep_a: assert property (
    (bor_mode[1] && i_sleep) |=> !o_brownout_reset_enable)
    else $error("brown-out on during sleep");
  bor_soft_a: assert property (
    (bor_mode == cfgd_pkg::cfgd_bor_soft) |=>
    (o_brownout_reset_enable == $past(ctrl_reg[`CFGD_CTRL_SBOR])))
    else $error("brown-out not following soft enable");
  bor_off_a: assert property (
    (bor_mode == cfgd_pkg::cfgd_bor_off) |=> !o_brownout_reset_enable)
    else $error("brown-out on while disabled");
  prot_bits_a: assert property (
    loaded_reg |=> (o_data_memory_protect == !word_reg[`CFGD_DPROT_BIT])
    && (o_program_memory_protect == !word_reg[`CFGD_PPROT_BIT]))
    else $error("protection polarity wrong");
  master_clear_reset_gate_a: assert property (
    !word_reg[`CFGD_MASTER_CLEAR_RESET_BIT] |=> !o_master_clear_reset && o_master_clear_pin_digital)
    else $error("reset line active with pin as input");
  power_up_delay_timer_pol_a: assert property (
    loaded_reg |=> (o_power_up_delay_timer_enable == !$past(word_reg[`CFGD_POWER_UP_DELAY_TIMER_BIT])))
    else $error("power-up timer polarity wrong");
  wdt_fuse_a: assert property (
    (loaded_reg && word_reg[`CFGD_WDT_BIT]) |=> o_watchdog_timer_enable)
    else $error("watchdog off with fuse set");
  osc_lp_a: assert property (
    (osc.mode == cfgd_pkg::cfgd_osc_low_power_crystal) |=> ##1
    (!o_osc1_gpio && !o_osc2_gpio && !o_clock_output_oe))
    else $error("crystal pins released");
  osc_free_a: assert property (
    (osc.mode == cfgd_pkg::cfgd_osc_internal_pins_free) |=> ##1
    (o_osc1_gpio && o_osc2_gpio && !o_clock_output_oe))
    else $error("internal mode pins not free");
  word_hold_a: assert property (
    loaded_reg |=> $stable(word_reg) && loaded_reg)
    else $error("latched word changed after load");
  bus_answer_a: assert property (
    acc_wait_s |=> acc_done_s)
    else $error("bus answer later than one cycle");
  // A control write lands on the answering edge only
  ctrl_write_a: assert property (
    wr_ctrl |=> (ctrl_reg == $past(i_avs_writedata[1:0])))
    else $error("control write lost");

  // Load happens in two steps: the synchroniser settles, then one capture
  sequence load_edge_s;
    settle_done && !loaded_reg;
  endsequence
  word_load_a: assert property (
    load_edge_s |=> loaded_reg && (word_reg == $past(word_sync)))
    else $error("configuration word not captured");
  // Pin select set: the synchronised pin level decides the reset request
  master_clear_reset_ext_a: assert property (
    (loaded_reg && word_reg[`CFGD_MASTER_CLEAR_RESET_BIT]) |=>
    (o_master_clear_reset == !$past(master_clear_reset_pin_sync)) && !o_master_clear_pin_digital)
    else $error("reset request not following pin");
  // Fuse clear: software alone decides the watchdog
  wdt_soft_a: assert property (
    (loaded_reg && !word_reg[`CFGD_WDT_BIT]) |=>
    (o_watchdog_timer_enable == $past(ctrl_reg[`CFGD_CTRL_SWDT])))
    else $error("watchdog not following soft enable");
  osc_sel_a: assert property (
    loaded_reg |=> (o_oscillator_mode_select == $past(word_reg[`CFGD_OSC_HI:`CFGD_OSC_LO])))
    else $error("oscillator mode output wrong");

  // Pin roles sit one flop further down than the mode
  osc_rc_out_a: assert property (
    (loaded_reg && osc.mode == cfgd_pkg::cfgd_osc_res_cap_clock_out) |=> ##1
    (!o_osc1_gpio && !o_osc2_gpio && o_clock_output_oe))
    else $error("clock-out resistor mode pins wrong");
  osc_rc_free_a: assert property (
    (loaded_reg && osc.mode == cfgd_pkg::cfgd_osc_res_cap_pin_free) |=> ##1
    (!o_osc1_gpio && o_osc2_gpio && !o_clock_output_oe))
    else $error("pin-free resistor mode pins wrong");
  osc_int_out_a: assert property (
    (loaded_reg && osc.mode == cfgd_pkg::cfgd_osc_internal_clock_out) |=> ##1
    (o_osc1_gpio && !o_osc2_gpio && o_clock_output_oe))
    else $error("clock-out internal mode pins wrong");
endmodule

// ===== tb/cfgd_programmer.sv
// Purpose: Stands in for the external programmer that burns the configuration word
// Assumes: The word is a static level seen by the decoder through its synchroniser
// Notes: Starts erased; a burn lands on a rising edge like any other input change
`timescale 1ns/10ps
module cfgd_programmer #(
  parameter int WORD_W = 14
) (
  input wire logic i_clk_sys,
  output logic [WORD_W-1:0] o_word
);
  // Erased array reads all ones until something is burnt
  initial o_word = '1;
  // Burn a new word; the decoder must not notice it until its next reset
  task automatic burn(input logic [WORD_W-1:0] w);
    @(posedge i_clk_sys);
    o_word <= w;
  endtask
endmodule

// ===== tb/config_word_decode_test.sv
// Purpose: Self-checking bench for the configuration word decoder
// Assumes: Avalon-MM answers within a few cycles; outputs settle within six cycles of reset
// Notes: Outputs are sampled on the falling edge; bus answers on the rising edge
`timescale 1ns/10ps
`include "cfgd_map.svh"
module config_word_decode_test;
  logic clk = 1'b0; // 50 MHz system clock
  logic rst_n = 1'b0; // Synchronous reset, low active
  logic sleep = 1'b0; // Core sleep level
  logic mpin = 1'b0; // Shared reset pin held low so the reset request shows
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_addr = 4'h0;
  logic [31:0] avs_wdata = 32'h0;
  logic [3:0] avs_be = 4'h0;
  logic [13:0] word; // Word from the programmer
  logic [31:0] rdata;
  logic wait_n_req;
  logic bor, dprot, pprot, mrst, mdig, power_up_delay_timer, wdt, osc1, osc2, clock_output, clkoe;
  logic [2:0] osc_sel;
  int error_cnt = 0;
  int comparisons = 0;
  logic [6:0] fuse_obs; // Grouped fuse decodes for compact compares
  logic [5:0] osc_obs; // Grouped oscillator decodes
  assign fuse_obs = {bor, dprot, pprot, mrst, mdig, power_up_delay_timer, wdt};
  assign osc_obs = {osc_sel, osc1, osc2, clkoe};

  // Clock generator
  initial
  begin
    forever #10 clk = ~clk;
  end

  cfgd_programmer #(.WORD_W(14)) i_cfgd_programmer (.i_clk_sys(clk), .o_word(word));

  cfgd_config_word_decode #(.WORD_W(14)) i_cfgd_config_word_decode (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_config_word(word), .i_master_clear_pin(mpin),
    .i_sleep(sleep), .i_avs_address(avs_addr), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_wdata), .i_avs_byteenable(avs_be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_n_req),
    .o_brownout_reset_enable(bor), .o_data_memory_protect(dprot),
    .o_program_memory_protect(pprot), .o_master_clear_reset(mrst),
    .o_master_clear_pin_digital(mdig), .o_power_up_delay_timer_enable(power_up_delay_timer),
    .o_watchdog_timer_enable(wdt), .o_oscillator_mode_select(osc_sel),
    .o_osc1_gpio(osc1), .o_osc2_gpio(osc2), .o_clock_output(clock_output),
    .o_clock_output_oe(clkoe));

  // One comparison; unknowns never match
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus cycle: request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_addr <= a;
    avs_wdata <= d;
    avs_be <= be;
    @(posedge clk);
    // Bounded wait so a dead slave cannot hang the run
    while (wait_n_req !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= 50)
      chk("waitrequest", 32'(wait_n_req), 32'h0);
    // Data taken and request released at the edge where waitrequest was low
    q = rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Reset for three cycles, then let the synchroniser and decode settle
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog: the tests need well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  // Main sequence
  initial
  begin
    logic [13:0] w;
    logic [2:0] k;
    logic [31:0] q;
    logic [7:0] s;
    // Every oscillator code, with the other fuses varied from the same index
    for (int i = 0; i < 8; i++)
    begin
      k = i[2:0];
      w = {4'ha, k[1:0], k[0], k[1], k[2], ~k[0], k[1], k};
      i_cfgd_programmer.burn(w);
      do_reset();
      chk("fuses", 32'(fuse_obs), 32'({k[1], ~k[0], ~k[1], k[2], ~k[2], k[0], k[1]}));
      chk("osc", 32'(osc_obs), 32'({k, k == 3'h5 || k == 3'h4, k == 3'h6 || k == 3'h4, k == 3'h7 || k == 3'h5}));
      bus(1'b0, `CFGD_OFS_WORD, 32'h0, 4'hf, q);
      chk("word", q, 32'(w));
      // Clock output: two high, two low, so samples two apart always differ
      if (k == 3'h7 || k == 3'h5)
      begin
        for (int j = 0; j < 8; j++)
        begin
          @(negedge clk);
          s[j] = clock_output;
        end
        for (int j = 0; j < 6; j++)
          chk("clkout", 32'(s[j] ^ s[j+2]), 32'h1);
      end
      $display("test osc code %0d done", i);
    end
    // Last word has brown-out code 11: off in sleep, back on when awake
    @(posedge clk);
    sleep <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("bor sleep", 32'(bor), 32'h0);
    @(posedge clk);
    sleep <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("bor run", 32'(bor), 32'h1);
    $display("test sleep done");
    // Brown-out code 01 and watchdog fuse 0: both follow the soft enables
    w = 14'h0177;
    i_cfgd_programmer.burn(w);
    do_reset();
    chk("soft off", 32'({bor, wdt}), 32'h0);
    bus(1'b1, `CFGD_OFS_CTRL, 32'h3, 4'hf, q);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("soft on", 32'({bor, wdt}), 32'h3);
    // Lane 0 disabled: the write must be ignored
    bus(1'b1, `CFGD_OFS_CTRL, 32'h0, 4'h0, q);
    bus(1'b0, `CFGD_OFS_CTRL, 32'h0, 4'hf, q);
    chk("ctrl", q, 32'h3);
    // Reburn and write the read-only word: nothing may move before the next reset
    i_cfgd_programmer.burn(14'h3fff);
    bus(1'b1, `CFGD_OFS_WORD, 32'h0, 4'hf, q);
    repeat (4) @(posedge clk);
    bus(1'b0, `CFGD_OFS_WORD, 32'h0, 4'hf, q);
    chk("word held", q, 32'(w));
    chk("fuses held", 32'(fuse_obs), 32'h69);
    // Pin high while it is the reset input: no reset request
    @(posedge clk);
    mpin <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("pin idle", 32'({mrst, mdig}), 32'h0);
    @(posedge clk);
    mpin <= 1'b0;
    bus(1'b0, 4'hc, 32'h0, 4'hf, q);
    chk("unmapped", q, 32'h0);
    bus(1'b1, `CFGD_OFS_CTRL, 32'h0, 4'h1, q);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("soft clr", 32'({bor, wdt}), 32'h0);
    // Status: mode 111, loaded, data protection on, everything else off
    bus(1'b0, `CFGD_OFS_STAT, 32'h0, 4'hf, q);
    chk("status", q, 32'h744);
    $display("test soft enables done");
    close_out();
  end
endmodule
